// *** core/fcnm_cfg.svh ***
`ifndef FCNM_CFG_SVH
`define FCNM_CFG_SVH
// Network sizes
`define FCNM_NUM_DYN 8
`define FCNM_DYN_IN 4
`define FCNM_NUM_GLB 32
`define FCNM_LOC_SIG 16
`define FCNM_FAB_SIG 16
`define FCNM_RGN_TB 8
`define FCNM_RGN_CORE 4
`define FCNM_CORE_H 80
`define FCNM_LOC_H 40
`define FCNM_NUM_LOC 4
`define FCNM_TB_GLB 14
`define FCNM_TB_FAB 2
`define FCNM_SIDE_CLK 4
`define FCNM_SIDE_FAB 2
// Static source vector field positions
`define FCNM_SRC_W 16
`define FCNM_SRC_PIN 0
`define FCNM_SRC_PLL 4
`define FCNM_SRC_OSC 8
`define FCNM_SRC_CORE 9
// Local pool positions
`define FCNM_POOL_FAB 32
`define FCNM_POOL_RGN 48
`define FCNM_POOL_GEN 63
`define FCNM_CORE_LIM 52
`define FCNM_TB_LIM 40
// Dynamic mux input selected when user mode begins
`define FCNM_DYN_RST_SEL 0
`endif

// *** core/fcnm_pkg.sv ***
package fcnm_pkg;
  // Dynamic mux switch sequence, one-hot
  typedef enum logic [2:0] {
    DM_RUN = 3'h1,
    DM_DRAIN = 3'h2,
    DM_ADOPT = 3'h4
  } fcnm_dm_state_t;
  typedef logic [1:0] fcnm_dsel_t;
  typedef logic [3:0] fcnm_ssel_t;
  typedef logic [5:0] fcnm_pidx_t;
endpackage : fcnm_pkg

// *** core/fcnm_top.sv ***
// Contract
// - Global network takes pins, PLL, oscillator, core
// - Eight dynamic muxes switchable in user mode
// - Enabled mux follows user select bus
// - Dynamic muxes start on input 0
// - Fifth PLL output only to top/bottom regional
// - Top/bottom regions serve only top/bottom interfaces
// - Core regions 80 tall, local nets 40
// - DSP and RAM get own local nets
// - Local net 16 from global, fabric, regional
// - Regional share 8 top/bottom, 4 elsewhere
// - Fabric makes local clocks and cell enables
// - Top/bottom interface: 14 global, 2 fabric
// - Side interface: 4 clocks, 2 fabric max
// - Alternate pin feeds PLL reference directly
// - Network enable switches without glitches
`timescale 1ns/1ps
`include "fcnm_cfg.svh"
module fcnm_top #(
  parameter int NUM_DYN = `FCNM_NUM_DYN,
  parameter int DYN_IN = `FCNM_DYN_IN,
  parameter int NUM_GLB = `FCNM_NUM_GLB,
  parameter int NUM_LOC = `FCNM_NUM_LOC,
  parameter int CORE_H = `FCNM_CORE_H
) (
  input wire logic ref_clk,
  input wire logic rst,
  input wire logic ce,
  input wire logic [DYN_IN-1:0] dyn_clk_in [NUM_DYN],
  input wire logic [NUM_DYN-1:0] dyn_en,
  input wire fcnm_pkg::fcnm_dsel_t dyn_sel [NUM_DYN],
  input wire logic [3:0] pin_clk,
  input wire logic [3:0] pll_clk,
  input wire logic [1:0] pll_fifth_output,
  input wire logic osc_clk,
  input wire logic [6:0] core_clk,
  input wire fcnm_pkg::fcnm_ssel_t stat_sel [NUM_GLB],
  input wire logic [NUM_GLB-1:0] net_en,
  input wire logic [`FCNM_RGN_CORE-1:0] rgn_core,
  input wire logic [6:0] rgn_tb_core [2],
  input wire logic [`FCNM_FAB_SIG-1:0] fab_clk,
  input wire logic [NUM_LOC-1:0] loc_gen,
  input wire fcnm_pkg::fcnm_pidx_t loc_sel [NUM_LOC][`FCNM_LOC_SIG],
  input wire fcnm_pkg::fcnm_pidx_t tb_sel [2][`FCNM_TB_GLB],
  input wire fcnm_pkg::fcnm_pidx_t side_sel [2][2],
  input wire logic [CORE_H-1:0] cell_ce,
  input wire logic [1:0] alt_mode,
  input wire logic [1:0] alt_pin,
  input wire logic [1:0] core_ref,
  output fcnm_pkg::fcnm_dsel_t dyn_act_ff [NUM_DYN],
  output logic [NUM_GLB-1:0] glb_ff,
  output logic [NUM_LOC-1:0][`FCNM_LOC_SIG-1:0] loc_ff,
  output logic [1:0][`FCNM_LOC_SIG-1:0] tb_loc_ff,
  output logic [1:0][`FCNM_SIDE_CLK-1:0] side_loc_ff,
  output logic [CORE_H-1:0] cell_ce_ff,
  output logic [1:0] pll_ref_ff
);
  import fcnm_pkg::*;

  // Pick one pool bit, index at or above the limit, other than 63, yields a quiet line
  function automatic logic pick(input logic [63:0] pool,
                                input logic [5:0] idx,
                                input logic [6:0] lim);
    logic r;
    r = 1'h0;
    if ({1'h0, idx} < lim || idx == 6'h3F) begin
      r = pool[idx];
    end
    return r;
  endfunction : pick

  logic dyn_out_ff [NUM_DYN];
  fcnm_dm_state_t dm_st_ff [NUM_DYN];
  fcnm_dsel_t pend_ff [NUM_DYN];
  logic [`FCNM_SRC_W-1:0] stat_src;
  logic [NUM_GLB-1:0] glb_src;
  logic [NUM_GLB-1:0] en_eff;
  logic [NUM_GLB-1:0] gate_on_ff;
  logic [`FCNM_RGN_TB-1:0] rgn_tb [2];

  // Dynamic multiplexers, one per generate pass
  genvar d;
  generate
    for (d = 0; d < NUM_DYN; d++) begin : g_dyn
      logic cur_clk;
      logic new_clk;
      assign cur_clk = dyn_clk_in[d][dyn_act_ff[d]];
      assign new_clk = dyn_clk_in[d][pend_ff[d]];

      // Glitch-free switch sequence
      always_ff @(posedge ref_clk or posedge rst) begin
        if (rst) begin
          dm_st_ff[d] <= DM_RUN;
          dyn_act_ff[d] <= fcnm_dsel_t'(`FCNM_DYN_RST_SEL);
          pend_ff[d] <= fcnm_dsel_t'(`FCNM_DYN_RST_SEL);
          dyn_out_ff[d] <= 1'h0;
        end else if (ce) begin
          unique case (dm_st_ff[d])
            DM_RUN: begin
              dyn_out_ff[d] <= cur_clk;
              if (dyn_en[d] && dyn_sel[d] != dyn_act_ff[d]) begin
                pend_ff[d] <= dyn_sel[d];
                dm_st_ff[d] <= DM_DRAIN;
              end
            end
            DM_DRAIN: begin
              // Let the current high phase finish, then stay low
              dyn_out_ff[d] <= dyn_out_ff[d] & cur_clk;
              if (!cur_clk) begin
                dm_st_ff[d] <= DM_ADOPT;
              end
            end
            DM_ADOPT: begin
              // Wait for a low phase of the new clock before joining
              dyn_out_ff[d] <= 1'h0;
              if (!new_clk) begin
                dyn_act_ff[d] <= pend_ff[d];
                dm_st_ff[d] <= DM_RUN;
              end
            end
          endcase
        end
      end

      dyn_reset_a: assert property (@(posedge ref_clk)
        $past(rst) && !rst |-> dyn_act_ff[d] == 2'h0)
        else $error("dynamic mux not on input 0 after reset");
      dyn_switch_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && dm_st_ff[d] == DM_RUN && dyn_en[d] &&
        dyn_sel[d] != dyn_act_ff[d] |=> dm_st_ff[d] == DM_DRAIN &&
        pend_ff[d] == $past(dyn_sel[d]))
        else $error("select change not taken");
      dyn_gap_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        ce && dm_st_ff[d] == DM_ADOPT |=> !dyn_out_ff[d])
        else $error("output not low during switch");
      dyn_hold_a: assert property (
        @(posedge ref_clk) disable iff (rst)
        !(ce && dm_st_ff[d] == DM_ADOPT) |=> $stable(dyn_act_ff[d]))
        else $error("active input changed outside switch");
    end
  endgenerate

  // Static source vector; fifth PLL output is kept out of it
  assign stat_src = {core_clk, osc_clk, pll_clk, pin_clk};

  // Global line sources: dynamic muxes first, static muxes after
  always_comb begin
    for (int g = 0; g < NUM_GLB; g++) begin
      if (g < NUM_DYN) begin
        glb_src[g] = dyn_out_ff[g];
      end else begin
        glb_src[g] = stat_src[stat_sel[g]];
      end
    end
  end

  // Enable may only change while the line is low
  always_comb begin
    for (int g = 0; g < NUM_GLB; g++) begin
      en_eff[g] = glb_src[g] ? gate_on_ff[g] : net_en[g];
    end
  end

  // Gated global network
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      gate_on_ff <= '0;
      glb_ff <= '0;
    end else if (ce) begin
      gate_on_ff <= en_eff;
      glb_ff <= glb_src & en_eff;
    end
  end

  glb_gate_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && glb_src[NUM_DYN] |=> $stable(gate_on_ff[NUM_DYN]))
    else $error("gate moved while line high");
  glb_pass_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && gate_on_ff[0] && net_en[0] |=> glb_ff[0] == $past(glb_src[0]))
    else $error("enabled global line not passing");

  // Top/bottom regional: fifth PLL output plus core drive
  assign rgn_tb[0] = {rgn_tb_core[0], pll_fifth_output[0]};
  assign rgn_tb[1] = {rgn_tb_core[1], pll_fifth_output[1]};

  // Core local networks: two 40-cell halves, then DSP and RAM
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      loc_ff <= '0;
    end else if (ce) begin
      for (int n = 0; n < NUM_LOC; n++) begin
        for (int s = 0; s < `FCNM_LOC_SIG; s++) begin
          loc_ff[n][s] <= pick({loc_gen[n], 11'h000, rgn_core, fab_clk,
                                glb_ff}, loc_sel[n][s],
                               7'(`FCNM_CORE_LIM));
        end
      end
    end
  end

  loc_range_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && loc_sel[0][0] >= 6'(`FCNM_CORE_LIM) && loc_sel[0][0] != 6'h3F
    |=> !loc_ff[0][0])
    else $error("local net took an out-of-budget source");

  // Per-cell clock enable from local fabric
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      cell_ce_ff <= '0;
    end else if (ce) begin
      cell_ce_ff <= cell_ce;
    end
  end

  // Top/bottom interface locals: only these see top/bottom regional
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      tb_loc_ff <= '0;
    end else if (ce) begin
      for (int r = 0; r < 2; r++) begin
        for (int s = 0; s < `FCNM_TB_GLB; s++) begin
          tb_loc_ff[r][s] <= pick({24'h000000, rgn_tb[r], glb_ff},
                                  tb_sel[r][s], 7'(`FCNM_TB_LIM));
        end
        for (int s = 0; s < `FCNM_TB_FAB; s++) begin
          tb_loc_ff[r][`FCNM_TB_GLB + s] <= fab_clk[2 * r + s];
        end
      end
    end
  end

  tb_fab_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce |=> tb_loc_ff[1][`FCNM_TB_GLB] == $past(fab_clk[2]))
    else $error("interface fabric clock slot wrong");

  // Side interface locals: two fabric, two global/regional
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      side_loc_ff <= '0;
    end else if (ce) begin
      for (int r = 0; r < 2; r++) begin
        for (int s = 0; s < `FCNM_SIDE_FAB; s++) begin
          side_loc_ff[r][s] <= fab_clk[8 + 2 * r + s];
          side_loc_ff[r][`FCNM_SIDE_FAB + s] <=
            pick({28'h0000000, rgn_core, glb_ff}, side_sel[r][s],
                 7'(36));
        end
      end
    end
  end

  // PLL reference: alternate pin bypasses the core path
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) begin
      pll_ref_ff <= '0;
    end else if (ce) begin
      for (int p = 0; p < 2; p++) begin
        pll_ref_ff[p] <= alt_mode[p] ? alt_pin[p] : core_ref[p];
      end
    end
  end

  pll_alt_a: assert property (@(posedge ref_clk) disable iff (rst)
    ce && alt_mode[0] |=> pll_ref_ff[0] == $past(alt_pin[0]))
    else $error("alternate pin not on PLL reference");
endmodule : fcnm_top

// *** test/fcnm_user.sv ***
`timescale 1ns/1ps
// Core-side clock sources for the dynamic muxes
module fcnm_user (
  input wire logic ref_clk,
  input wire logic rst,
  output logic [3:0] dyn_clk_in [8]
);
  logic [4:0] cnt_ff;
  // Free-running count; input k toggles every 2^k cycles
  always_ff @(posedge ref_clk or posedge rst) begin
    if (rst) cnt_ff <= 5'h00;
    else cnt_ff <= cnt_ff + 5'h01;
  end
  // Input 0 and every other input keep toggling
  always_comb begin
    for (int m = 0; m < 8; m++) dyn_clk_in[m] = cnt_ff[3:0];
  end
endmodule : fcnm_user

// *** test/tb.sv ***
`timescale 1ns/1ps
module tb;
  import fcnm_pkg::*;
  logic ref_clk, rst, ce, osc_clk;
  logic [3:0] dyn_clk_in [8];
  logic [7:0] dyn_en;
  fcnm_dsel_t dyn_sel [8];
  fcnm_dsel_t dyn_act_ff [8];
  logic [3:0] pin_clk, pll_clk, rgn_core, loc_gen;
  logic [1:0] pll_fifth_output, alt_mode, alt_pin, core_ref, pll_ref_ff;
  logic [6:0] core_clk;
  logic [6:0] rgn_tb_core [2];
  fcnm_ssel_t stat_sel [32];
  logic [31:0] net_en, glb_ff;
  logic [15:0] fab_clk;
  fcnm_pidx_t loc_sel [4][16];
  fcnm_pidx_t tb_sel [2][14];
  fcnm_pidx_t side_sel [2][2];
  logic [79:0] cell_ce, cell_ce_ff;
  logic [3:0][15:0] loc_ff;
  logic [1:0][15:0] tb_loc_ff;
  logic [1:0][3:0] side_loc_ff;
  int n_errors = 0;
  int checks = 0;
  fcnm_user user (.ref_clk, .rst, .dyn_clk_in);
  fcnm_top uut (.ref_clk, .rst, .ce, .dyn_clk_in, .dyn_en, .dyn_sel,
    .pin_clk, .pll_clk, .pll_fifth_output, .osc_clk, .core_clk, .stat_sel,
    .net_en, .rgn_core, .rgn_tb_core, .fab_clk, .loc_gen, .loc_sel, .tb_sel,
    .side_sel, .cell_ce, .alt_mode, .alt_pin, .core_ref, .dyn_act_ff,
    .glb_ff, .loc_ff, .tb_loc_ff, .side_loc_ff, .cell_ce_ff, .pll_ref_ff);
  // Clock generator
  initial begin
    ref_clk = 1'b0;
    forever #20 ref_clk = ~ref_clk;
  end
  task automatic chk(input string what, input logic [79:0] seen, exp);
    checks++;
    if (seen !== exp) begin
      n_errors++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk
  task automatic step(input int n);
    repeat (n) @(posedge ref_clk);
    #1;
  endtask : step
  task automatic report_and_stop;
    if (n_errors == 0 && checks > 0) $display("ALL TESTS PASSED");
    else $display("TESTS FAILED");
    $finish;
  endtask : report_and_stop
  // Switch seven muxes, keep one disabled, then watch line 0
  task automatic t_dyn;
    int hi;
    int rises;
    logic prev;
    dyn_en = 8'hFD;
    foreach (dyn_sel[m]) dyn_sel[m] = 2'h1;
    step(20);
    foreach (dyn_act_ff[m]) begin
      chk("dyn_act", dyn_act_ff[m], (m == 1) ? 2'h0 : 2'h1);
    end
    foreach (dyn_sel[m]) dyn_sel[m] = 2'h3;
    step(40);
    foreach (dyn_act_ff[m]) begin
      chk("dyn_act", dyn_act_ff[m], (m == 1) ? 2'h0 : 2'h3);
    end
    hi = 0;
    rises = 0;
    prev = glb_ff[0];
    repeat (16) begin
      step(1);
      if (glb_ff[0] === 1'b1) hi++;
      if (glb_ff[0] === 1'b1 && prev === 1'b0) rises++;
      prev = glb_ff[0];
    end
    chk("glb0 highs", 80'(hi), 80'h8);
    chk("glb0 rises", 80'(rises), 80'h1);
  endtask : t_dyn
  task automatic t_src(input logic [15:0] pat, exp);
    {core_clk, osc_clk, pll_clk, pin_clk} = pat;
    step(3);
    chk("glb static", glb_ff[23:8], exp);
  endtask : t_src
  // Static sources, then gating that waits for a low source
  task automatic t_static;
    t_src(16'hA5C3, 16'hA5C3);
    t_src(16'h5A3C, 16'h5A3C);
    net_en = 32'hFF0000FF;
    t_src(16'h5A3C, 16'h5A3C);
    t_src(16'h0000, 16'h0000);
    t_src(16'hFFFF, 16'h0000);
    net_en = 32'hFFFFFFFF;
    t_src(16'h0000, 16'h0000);
    t_src(16'hFFFF, 16'hFFFF);
  endtask : t_static
  // Local, interface-region and side selections with pool limits
  task automatic t_local;
    fab_clk = 16'h5AC3;
    rgn_core = 4'h9;
    loc_gen = 4'hA;
    pll_fifth_output = 2'h1;
    rgn_tb_core[0] = 7'h55;
    rgn_tb_core[1] = 7'h2A;
    foreach (loc_sel[n, k]) loc_sel[n][k] = 6'(32 + k);
    foreach (tb_sel[r, k]) tb_sel[r][k] = 6'(32 + k);
    for (int n = 0; n < 4; n++) begin
      loc_sel[n][0] = 6'h30;
      loc_sel[n][1] = 6'h33;
      loc_sel[n][2] = 6'h34;
      loc_sel[n][3] = 6'h3F;
    end
    for (int r = 0; r < 2; r++) begin
      side_sel[r][0] = 6'h20;
      side_sel[r][1] = 6'h24;
    end
    step(3);
    for (int n = 0; n < 4; n++) begin
      chk("loc", loc_ff[n], {12'h5AC, loc_gen[n], 3'h3});
    end
    for (int r = 0; r < 2; r++) begin
      chk("tb_loc", tb_loc_ff[r], {fab_clk[2*r+1], fab_clk[2*r], 6'h00,
        rgn_tb_core[r], pll_fifth_output[r]});
      chk("side_loc", side_loc_ff[r], {1'b0, rgn_core[0],
        fab_clk[9+2*r], fab_clk[8+2*r]});
    end
  endtask : t_local
  // Per-cell enables, frozen while ce is low
  task automatic t_ce;
    cell_ce = 80'hF0E1D2C3B4A596877869;
    step(2);
    chk("cell_ce", cell_ce_ff, 80'hF0E1D2C3B4A596877869);
    ce = 1'b0;
    cell_ce = ~cell_ce;
    step(3);
    chk("cell_ce", cell_ce_ff, 80'hF0E1D2C3B4A596877869);
    ce = 1'b1;
    step(2);
    chk("cell_ce", cell_ce_ff, ~80'hF0E1D2C3B4A596877869);
  endtask : t_ce
  // PLL reference from alternate pin or core path, per PLL
  task automatic t_pll;
    alt_mode = 2'h1;
    alt_pin = 2'h1;
    core_ref = 2'h2;
    step(2);
    chk("pll_ref", pll_ref_ff, 2'h3);
    alt_mode = 2'h2;
    step(2);
    chk("pll_ref", pll_ref_ff, 2'h0);
  endtask : t_pll
  // Second reset in mid-run sends every mux back to input 0
  task automatic t_rst;
    rst = 1'b1;
    step(2);
    foreach (dyn_act_ff[m]) chk("act rst", dyn_act_ff[m], 2'h0);
    chk("pll_ref rst", pll_ref_ff, 2'h0);
    rst = 1'b0;
    step(2);
    foreach (dyn_act_ff[m]) chk("act rerun", dyn_act_ff[m], 2'h0);
  endtask : t_rst
  // Main sequence
  initial begin
    rst = 1'b1;
    ce = 1'b1;
    dyn_en = 8'h00;
    foreach (dyn_sel[m]) dyn_sel[m] = 2'h0;
    {core_clk, osc_clk, pll_clk, pin_clk} = 16'h0000;
    foreach (stat_sel[j]) stat_sel[j] = 4'(j - 8);
    net_en = 32'hFFFFFFFF;
    {rgn_core, loc_gen, fab_clk, pll_fifth_output} = 26'h0000000;
    rgn_tb_core = '{7'h00, 7'h00};
    foreach (loc_sel[n, k]) loc_sel[n][k] = 6'h00;
    foreach (tb_sel[r, k]) tb_sel[r][k] = 6'h00;
    foreach (side_sel[r, k]) side_sel[r][k] = 6'h00;
    cell_ce = 80'h0;
    {alt_mode, alt_pin, core_ref} = 6'h00;
    step(20);
    chk("act in reset", dyn_act_ff[0], 2'h0);
    rst = 1'b0;
    step(2);
    foreach (dyn_act_ff[m]) chk("act start", dyn_act_ff[m], 2'h0);
    t_dyn();
    t_static();
    t_local();
    t_ce();
    t_pll();
    t_rst();
    report_and_stop();
  end
  // Watchdog
  initial begin
    #(2000 * 40);
    n_errors++;
    report_and_stop();
  end
endmodule : tb
